// [src/dsm_exec.sv]
// decrement-skip and multiply execution unit with its register port
//
// Design decisions made here: the register offsets and the address-and-strobe port.
module dsm_exec
   import dsm_pkg::*;
#(
   parameter int unsigned PHASE_DIV = PHASE_DIV_DEF
) (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   // instruction port
   input  wire logic                instr_valid,
   input  wire logic [INSTR_W-1:0]  instr_word,
   input  wire logic                next_two_word,
   output logic                     instr_ready,
   output logic                     nop_active,
   output logic                     skip_taken_q,
   output logic                     cycle_start,
   // data memory port
   output logic      [ADDR_W-1:0]   dmem_addr_q,
   output logic                     dmem_rd_q,
   output logic                     dmem_wr_q,
   output logic      [DATA_W-1:0]   dmem_wdata_q,
   input  wire logic [DATA_W-1:0]   dmem_rdata,
   // register port
   input  wire logic [REG_AW-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [DATA_W-1:0]   reg_rdata_q,
   output logic      [DATA_W-1:0]   acc_q
);
   // ==========================================================
   // decode helpers
   function automatic dsm_op_e decode_op(input logic [INSTR_W-1:0] w);
      dsm_op_e op;
      op = OP_NONE;
      if (w[15:10] == OPC_DEC_SKIP_Z) begin
         op = OP_DSZ;
      end else if (w[15:10] == OPC_DEC_SKIP_NZ) begin
         op = OP_DSNZ;
      end else if (w[15:8] == OPC_MUL_LIT) begin
         op = OP_MULL;
      end else if (w[15:9] == OPC_MUL_FILE) begin
         op = OP_MULF;
      end
      return op;
   endfunction

   function automatic logic is_decrement(input dsm_op_e op);
      return (op == OP_DSZ) || (op == OP_DSNZ);
   endfunction

   // ==========================================================
   // phase divider
   localparam int unsigned DIV_W = (PHASE_DIV > 1) ? $clog2(PHASE_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PHASE_DIV - 1);

   logic [DIV_W-1:0] div_q;
   logic [1:0]       phase_q;
   wire              phase_en = (div_q == DIV_LAST);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= '0;
      end else begin
         div_q <= phase_en ? '0 : div_q + DIV_W'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= PH_Q1;
      end else if (phase_en) begin
         phase_q <= phase_q + 2'h1;
      end
   end

   wire at_q1 = phase_en && (phase_q == PH_Q1);
   wire at_q3 = phase_en && (phase_q == PH_Q3);
   wire at_q4 = phase_en && (phase_q == PH_Q4);

   // ==========================================================
   // software registers
   logic              ext_en_q;
   logic [BANK_W-1:0] bank_q;
   logic [ADDR_W-1:0] idx_base_q;
   logic [DATA_W-1:0] prod_lo_q;
   logic [DATA_W-1:0] prod_hi_q;
   logic [DATA_W-1:0] acc_d;

   wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
   wire wr_bank = reg_wr && (reg_addr == OFS_BANK_SEL);
   wire wr_work = reg_wr && (reg_addr == OFS_WORK);
   wire wr_idxl = reg_wr && (reg_addr == OFS_IDX_LO);
   wire wr_idxh = reg_wr && (reg_addr == OFS_IDX_HI);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_en_q   <= 1'b0;
         bank_q     <= RST_BANK;
         idx_base_q <= RST_IDX;
      end else begin
         if (wr_ctrl) ext_en_q <= reg_wdata[0];
         if (wr_bank) bank_q <= reg_wdata[BANK_W-1:0];
         if (wr_idxl) idx_base_q[7:0] <= reg_wdata;
         if (wr_idxh) idx_base_q[11:8] <= reg_wdata[3:0];
      end
   end

   // ==========================================================
   // state machine
   dsm_state_e        st_q;
   dsm_state_e        st_d;
   dsm_op_e           op_q;
   logic [INSTR_W-1:0] iw_q;
   logic              two_word_q;
   logic [1:0]        nop_left_q;
   logic [DATA_W-1:0] dec_q;

   wire dsm_op_e in_op  = decode_op(instr_word);
   wire          accept = at_q1 && (st_q == ST_IDLE) && instr_valid
                          && (in_op != OP_NONE);
   wire          q_dec  = is_decrement(op_q);
   wire          q_mul  = (op_q == OP_MULL) || (op_q == OP_MULF);

   // skip decision taken on the freshly decremented value
   wire skip_now = ((op_q == OP_DSZ) && (dec_q == RST_BYTE))
                || ((op_q == OP_DSNZ) && (dec_q != RST_BYTE));
   wire [1:0] nop_count = two_word_q ? NOP_TWO_WORD
                                     : NOP_ONE_WORD;

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (accept) st_d = ST_EXEC;
         end
         ST_EXEC: begin
            if (at_q4) st_d = (q_dec && skip_now) ? ST_SKIP : ST_IDLE;
         end
         ST_SKIP: begin
            if (at_q4 && (nop_left_q == NOP_ONE_WORD)) st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q       <= OP_NONE;
         iw_q       <= '0;
         two_word_q <= 1'b0;
      end else if (accept) begin
         op_q       <= in_op;
         iw_q       <= instr_word;
         two_word_q <= next_two_word;
      end
   end

   // one no-op instruction cycle per discarded word
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         nop_left_q <= 2'h0;
      end else if ((st_q == ST_EXEC) && at_q4) begin
         nop_left_q <= nop_count;
      end else if ((st_q == ST_SKIP) && at_q4) begin
         nop_left_q <= nop_left_q - 2'h1;
      end
   end

   // ==========================================================
   // operand address
   wire [7:0] in_f    = instr_word[7:0];
   wire       in_abit = instr_word[ACCESS_BIT];
   wire       in_file = (in_op == OP_DSZ) || (in_op == OP_DSNZ)
                        || (in_op == OP_MULF);
   wire       in_low  = (in_f <= ACCESS_SPLIT);
   wire       in_idx  = !in_abit && ext_en_q && in_low;
   wire [ADDR_W-1:0] idx_addr  = idx_base_q + {4'h0, in_f};
   wire [ADDR_W-1:0] bank_addr = {bank_q, in_f};
   wire [ADDR_W-1:0] acc_addr  = in_low ? {4'h0, in_f}
                                        : {ACCESS_HI_BANK, in_f};
   wire [ADDR_W-1:0] op_addr   = in_idx ? idx_addr
                               : (in_abit ? bank_addr : acc_addr);

   // ==========================================================
   // data path
   // read strobe sits in the second phase, data sampled in the third;
   // with PHASE_DIV above one the memory must hold its read data
   wire              use_lit = (op_q == OP_MULL);
   wire [DATA_W-1:0] opnd    = use_lit ? iw_q[7:0] : dmem_rdata;
   wire              exec_q3 = (st_q == ST_EXEC) && at_q3;
   wire              exec_q4 = (st_q == ST_EXEC) && at_q4;
   wire              to_file = q_dec && iw_q[DEST_BIT];
   wire              to_acc  = q_dec && !iw_q[DEST_BIT];
   logic [PROD_W-1:0] product;

   dsm_multiplier #(
      .W (DATA_W)
   ) u_mul (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .load      (exec_q3 && q_mul),
      .op_a      (acc_q),
      .op_b      (opnd),
      .product_q (product)
   );

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dec_q <= RST_BYTE;
      end else if (exec_q3 && q_dec) begin
         dec_q <= opnd - 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dmem_addr_q  <= '0;
         dmem_rd_q    <= 1'b0;
         dmem_wr_q    <= 1'b0;
         dmem_wdata_q <= RST_BYTE;
      end else begin
         dmem_rd_q <= accept && in_file;
         dmem_wr_q <= exec_q4 && to_file;
         if (accept) dmem_addr_q <= op_addr;
         if (exec_q4 && to_file) dmem_wdata_q <= dec_q;
      end
   end

   // product pair written in the fourth phase; the skip flag skip_taken_q is loaded in the same phase, set only by a taken skip
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prod_lo_q <= RST_BYTE;
         prod_hi_q <= RST_BYTE;
      end else if (exec_q4 && q_mul) begin
         prod_hi_q <= product[15:8];
         prod_lo_q <= product[7:0];
      end
   end

   // hardware write of the working register beats a software write
   always_comb begin
      acc_d = acc_q;
      if (exec_q4 && to_acc) begin
         acc_d = dec_q;
      end else if (wr_work) begin
         acc_d = reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= RST_BYTE;
      end else begin
         acc_q <= acc_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         skip_taken_q <= 1'b0;
      end else if (exec_q4) begin
         skip_taken_q <= q_dec && skip_now;
      end
   end

   // ==========================================================
   // handshake outputs
   assign instr_ready = at_q1 && (st_q == ST_IDLE);
   assign nop_active  = (st_q == ST_SKIP);
   assign cycle_start = at_q1;

   // ==========================================================
   // register read
   wire [DATA_W-1:0] status_w = {5'h00, skip_taken_q, nop_active,
                                 (st_q != ST_IDLE)};
   logic [DATA_W-1:0] rd_mux;

   always_comb begin
      case (reg_addr)
         OFS_CTRL:     rd_mux = {7'h00, ext_en_q};
         OFS_BANK_SEL: rd_mux = {4'h0, bank_q};
         OFS_WORK:     rd_mux = acc_q;
         OFS_IDX_LO:   rd_mux = idx_base_q[7:0];
         OFS_IDX_HI:   rd_mux = {4'h0, idx_base_q[11:8]};
         OFS_PROD_LO:  rd_mux = prod_lo_q;
         OFS_PROD_HI:  rd_mux = prod_hi_q;
         OFS_STATUS:   rd_mux = status_w;
         default:      rd_mux = RST_BYTE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_q <= RST_BYTE;
      end else begin
         reg_rdata_q <= reg_rd ? rd_mux : RST_BYTE;
      end
   end
endmodule // dsm_exec

// [src/dsm_multiplier.sv]
// unsigned 8x8 multiplier, product captured on a load enable
module dsm_multiplier
   import dsm_pkg::*;
#(
   parameter int unsigned W = DATA_W
) (
   input  wire logic           ref_clk,
   input  wire logic           rst_n,
   input  wire logic           load,
   input  wire logic [W-1:0]   op_a,
   input  wire logic [W-1:0]   op_b,
   output logic      [2*W-1:0] product_q
);
   // ==========================================================
   // product register
   // no carry or zero indication is produced, by design
   wire [2*W-1:0] product_d = op_a * op_b;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         product_q <= '0;
      end else if (load) begin
         product_q <= product_d;
      end
   end
endmodule // dsm_multiplier

// [src/dsm_pkg.sv]
// constants, encodings and types shared by the decrement-skip/multiply unit
package dsm_pkg;
   // ==========================================================
   // widths
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned ADDR_W   = 12;
   localparam int unsigned BANK_W   = 4;
   localparam int unsigned PROD_W   = 16;
   localparam int unsigned INSTR_W  = 16;
   localparam int unsigned REG_AW   = 4;
   localparam int unsigned CLK_MHZ  = 250;

   // ==========================================================
   // instruction fields
   localparam int unsigned DEST_BIT   = 9;
   localparam int unsigned ACCESS_BIT = 8;
   localparam logic [5:0] OPC_DEC_SKIP_Z  = 6'h0B;
   localparam logic [5:0] OPC_DEC_SKIP_NZ = 6'h13;
   localparam logic [7:0] OPC_MUL_LIT     = 8'h0D;
   localparam logic [6:0] OPC_MUL_FILE    = 7'h01;
   localparam logic [7:0] ACCESS_SPLIT    = 8'h5F;
   localparam logic [3:0] ACCESS_HI_BANK  = 4'hF;

   // ==========================================================
   // phases of one instruction cycle
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;
   localparam int unsigned PHASE_DIV_DEF = 1;
   localparam logic [1:0] NOP_ONE_WORD = 2'h1;
   localparam logic [1:0] NOP_TWO_WORD = 2'h2;

   // ==========================================================
   // register offsets and reset values
   localparam logic [3:0] OFS_CTRL     = 4'h0;
   localparam logic [3:0] OFS_BANK_SEL = 4'h1;
   localparam logic [3:0] OFS_WORK     = 4'h2;
   localparam logic [3:0] OFS_IDX_LO   = 4'h3;
   localparam logic [3:0] OFS_IDX_HI   = 4'h4;
   localparam logic [3:0] OFS_PROD_LO  = 4'h5;
   localparam logic [3:0] OFS_PROD_HI  = 4'h6;
   localparam logic [3:0] OFS_STATUS   = 4'h7;
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [3:0] RST_BANK     = 4'h0;
   localparam logic [11:0] RST_IDX     = 12'h000;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_SKIP = 3'b100
   } dsm_state_e;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_DSZ  = 3'h1,
      OP_DSNZ = 3'h2,
      OP_MULL = 3'h3,
      OP_MULF = 3'h4
   } dsm_op_e;
endpackage

// [testbench/dsm_exec_props.sv]
// port checker for the decrement-skip/multiply unit
module dsm_exec_props
   import dsm_pkg::*;
(
   input wire logic                ref_clk,
   input wire logic                rst_n,
   input wire logic                instr_valid,
   input wire logic [INSTR_W-1:0]  instr_word,
   input wire logic                instr_ready,
   input wire logic                nop_active,
   input wire logic                skip_taken_q,
   input wire logic                cycle_start,
   input wire logic                dmem_rd_q,
   input wire logic                dmem_wr_q,
   input wire logic [DATA_W-1:0]   dmem_wdata_q,
   input wire logic [DATA_W-1:0]   dmem_rdata,
   input wire logic [DATA_W-1:0]   acc_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire mul_acc = instr_ready && instr_valid
                  && instr_word[15:8] == OPC_MUL_LIT;
   // ==========================================================
   // assertions
   a_ready_phase: assert property (instr_ready |-> cycle_start)
      else $error("ready outside first phase");
   a_cycle_period: assert property
      (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
      else $error("instruction cycle not four phases");
   a_rd_pulse: assert property (dmem_rd_q |=> !dmem_rd_q)
      else $error("operand read longer than one cycle");
   a_wr_after_rd: assert property (dmem_wr_q |-> $past(dmem_rd_q, 3))
      else $error("write not three cycles after read");
   a_wdata_dec: assert property
      (dmem_wr_q |-> dmem_wdata_q == 8'($past(dmem_rdata, 2) - 8'h01))
      else $error("written value is not operand minus one");
   a_nop_len: assert property ($rose(nop_active) |-> nop_active [*4])
      else $error("no-op shorter than one cycle");
   a_nop_no_ready: assert property (nop_active |-> !instr_ready)
      else $error("instruction taken during no-op");
   a_skip_flag: assert property ($rose(nop_active) |-> skip_taken_q)
      else $error("no-op without a taken skip");
   a_acc_keep: assert property (mul_acc |=> $stable(acc_q) [*4])
      else $error("multiply changed working register");
   // ==========================================================
   // covers
   c_skip: cover property ($rose(nop_active));
   c_mul: cover property (mul_acc);
   c_wr: cover property (dmem_wr_q);
endmodule // dsm_exec_props

// [testbench/dsm_exec_tb.sv]
// self-checking bench for the decrement-skip/multiply unit
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin \
   err_count++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module dsm_exec_tb
   import dsm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk = 0, rst_n = 0, instr_valid = 0;
   logic        next_two_word = 0, reg_wr = 0, reg_rd = 0;
   logic [15:0] instr_word = '0;
   logic [7:0]  dmem_rdata = '0, reg_wdata = '0, mem_val = '0;
   logic [7:0]  wr_dat, d;
   logic [3:0]  reg_addr = '0;
   logic        instr_ready, nop_active, skip_taken_q, cycle_start;
   logic        dmem_rd_q, dmem_wr_q, wr_seen;
   logic [11:0] dmem_addr_q;
   logic [7:0]  dmem_wdata_q, reg_rdata_q, acc_q;
   int          err_count = 0, comparisons = 0;
   always #2 ref_clk = ~ref_clk;
   dsm_exec #(.PHASE_DIV(1)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
      .instr_valid(instr_valid), .instr_word(instr_word),
      .next_two_word(next_two_word), .instr_ready(instr_ready),
      .nop_active(nop_active), .skip_taken_q(skip_taken_q),
      .cycle_start(cycle_start), .dmem_addr_q(dmem_addr_q),
      .dmem_rd_q(dmem_rd_q), .dmem_wr_q(dmem_wr_q),
      .dmem_wdata_q(dmem_wdata_q), .dmem_rdata(dmem_rdata),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .acc_q(acc_q));
   // ==========================================================
   // memory side: data only in the cycle after the strobe
   always @(posedge ref_clk) begin
      dmem_rdata <= dmem_rd_q ? mem_val : ~mem_val;
      if (dmem_wr_q === 1'b1) begin
         wr_seen <= 1'b1;
         wr_dat  <= dmem_wdata_q;
      end
   end
   // ==========================================================
   // tasks
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata_q;
   endtask
   // waits are bounded; the second count is the cycle cost
   task automatic exec(input logic [15:0] w, input logic two,
                       input logic [7:0] m, input int cyc);
      int n;
      mem_val = m;
      wr_seen = 1'b0;
      @(posedge ref_clk);
      instr_word    <= w;
      next_two_word <= two;
      instr_valid   <= 1'b1;
      n = 0;
      do begin @(negedge ref_clk); n++; end
      while (instr_ready !== 1'b1 && n < 20);
      if (n >= 20) begin err_count++; print_verdict; end
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      n = 0;
      do begin @(negedge ref_clk); n++; end
      while (instr_ready !== 1'b1 && n < 30);
      `CHK("cycles", cyc, n)
      @(posedge ref_clk);
      #1;
   endtask
   task automatic check_prod(input logic [15:0] p);
      reg_read(OFS_PROD_LO, d);
      `CHK("prod_lo", p[7:0], d)
      reg_read(OFS_PROD_HI, d);
      `CHK("prod_hi", p[15:8], d)
      `CHK("acc", 8'hC4, acc_q)
   endtask
   task automatic dec(input logic [15:0] w, input logic two,
                      input logic [7:0] m, input int cyc,
                      input logic [11:0] ad, input logic [7:0] ac);
      exec(w, two, m, cyc);
      `CHK("addr", ad, dmem_addr_q)
      `CHK("wr", w[DEST_BIT], wr_seen)
      if (w[DEST_BIT]) `CHK("wdata", 8'(m - 8'h01), wr_dat)
      `CHK("acc", ac, acc_q)
   endtask
   // ==========================================================
   // sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 10; a++) begin
         reg_read(4'(a), d);
         `CHK("reg", 8'h00, d)
      end
      $display("test reset done");
      reg_write(OFS_WORK, 8'hC4);
      exec({OPC_MUL_LIT, 8'hE2}, 1'b0, 8'h00, 4);
      check_prod(16'h00C4 * 16'h00E2);
      exec({OPC_MUL_LIT, 8'h00}, 1'b0, 8'h00, 4);
      check_prod(16'h0000);
      reg_write(OFS_BANK_SEL, 8'h03);
      exec({OPC_MUL_FILE, 1'b1, 8'h21}, 1'b0, 8'hB5, 4);
      `CHK("addr", 12'h321, dmem_addr_q)
      `CHK("wr", 1'b0, wr_seen)
      check_prod(16'h00C4 * 16'h00B5);
      $display("test multiply done");
      dec({OPC_DEC_SKIP_Z, 2'b11, 8'h21}, 0, 8'h01, 8, 12'h321, 8'hC4);
      dec({OPC_DEC_SKIP_Z, 2'b11, 8'h21}, 1, 8'h01, 12, 12'h321, 8'hC4);
      dec({OPC_DEC_SKIP_Z, 2'b00, 8'h10}, 0, 8'h05, 4, 12'h010, 8'h04);
      dec({OPC_DEC_SKIP_NZ, 2'b10, 8'h60}, 1, 8'h05, 12, 12'hF60, 8'h04);
      dec({OPC_DEC_SKIP_NZ, 2'b10, 8'h60}, 0, 8'h01, 4, 12'hF60, 8'h04);
      dec({OPC_DEC_SKIP_NZ, 2'b01, 8'h05}, 0, 8'h00, 8, 12'h305, 8'hFF);
      $display("test decrement done");
      reg_write(OFS_CTRL, 8'h01);
      reg_write(OFS_IDX_LO, 8'h40);
      reg_write(OFS_IDX_HI, 8'h02);
      dec({OPC_DEC_SKIP_Z, 2'b10, 8'h5F}, 0, 8'h03, 4, 12'h29F, 8'hFF);
      dec({OPC_DEC_SKIP_Z, 2'b10, 8'h60}, 0, 8'h03, 4, 12'hF60, 8'hFF);
      $display("test indexed done");
      print_verdict;
   end
endmodule // dsm_exec_tb
bind dsm_exec dsm_exec_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
   .instr_valid(instr_valid), .instr_word(instr_word),
   .instr_ready(instr_ready), .nop_active(nop_active),
   .skip_taken_q(skip_taken_q), .cycle_start(cycle_start),
   .dmem_rd_q(dmem_rd_q), .dmem_wr_q(dmem_wr_q),
   .dmem_wdata_q(dmem_wdata_q), .dmem_rdata(dmem_rdata), .acc_q(acc_q));
